// ---- rtl/swm_pkg.sv ----
// Overview of operation
// RULE1 - Carry flag bit 7 set on add carry or subtract borrow, else cleared.
// RULE2 - Half-carry bit 6 set on carry into or borrow from high nibble.
// RULE3 - Bank select bits 4:3 place R0-R7 at 0x00, 0x08, 0x10 or 0x18.
// RULE4 - Overflow bit 2 set on multiply product over 255 or divide by zero.
// RULE5 - Overflow cleared by add, add-carry, subtract, multiply, divide otherwise.
// RULE6 - Parity bit 0 is one when accumulator holds odd count of ones.
// RULE7 - Bits 5 and 1 are plain software flags, each bit-addressable.
// RULE8 - Status word at 0xD0, bit-addressable, resets to all zeros.
// RULE9 - Program memory spans 0x0000-0x3FFF; 0x3E00-0x3FFF withheld from user code.
// RULE10 - Program memory never written; bytes read only through code-read move.
// RULE11 - Lower 128 RAM bytes reachable directly and indirectly.
// RULE12 - Direct above 0x7F picks special registers; indirect picks upper RAM.
// RULE13 - Bit addresses 0x00-0x7F map to bytes 0x20-0x2F, eight bits per byte.
// RULE14 - Push writes at stack pointer plus one, then stack pointer increments.
// RULE15 - Reset loads stack pointer with 0x07, so first push lands at 0x08.
// RULE16 - Indirect accesses take address from R0 or R1 of current bank.
// RULE17 - External move with 8-bit address takes high byte from page register.
// RULE18 - Data pointer external move ignores upper 6 bits; 1 KB RAM aliases.
// RULE19 - Page register keeps bits 1:0 only; bits 7:2 read zero.
// RULE20 - Only special registers at addresses ending 0 or 8 are bit-addressable.
// RULE21 - Status word write leaves parity bit unchanged; hardware derives it.
package swm_pkg;
   localparam logic [7:0]  PSW_ADDR      = 8'hd0;
   localparam logic [7:0]  SP_ADDR       = 8'h81;
   localparam logic [7:0]  ACC_ADDR      = 8'he0;
   localparam logic [7:0]  PAGE_ADDR     = 8'haa;
   localparam logic [7:0]  PSW_RESET     = 8'h00;
   localparam logic [7:0]  SP_RESET      = 8'h07;
   localparam logic [7:0]  PAGE_RESET    = 8'h00;
   localparam logic [7:0]  SFR_BASE      = 8'h80;
   localparam logic [7:0]  BIT_BYTE_BASE = 8'h20;
   localparam logic [8:0]  MUL_LIMIT     = 9'h0ff;
   localparam logic [15:0] CODE_USER_END = 16'h3dff;
   localparam int          CY_POS        = 7;
   localparam int          AC_POS        = 6;
   localparam int          UFA_POS       = 5;
   localparam int          RS_HI         = 4;
   localparam int          RS_LO         = 3;
   localparam int          OV_POS        = 2;
   localparam int          UFB_POS       = 1;
   localparam int          PAR_POS       = 0;
   localparam int          PAGE_BITS     = 2;
   localparam int          ON_CHIP_XDATA_RAM_AW       = 10;

   typedef enum logic [2:0] {
      SWM_OP_NONE, SWM_OP_ADD, SWM_OP_ADD_WITH_CARRY_OP, SWM_OP_SUBTRACT_BORROW_OP, SWM_OP_MUL, SWM_OP_DIV, SWM_OP_OTHER
   } swm_alu_op_e;

   typedef enum logic [1:0] {
      SWM_MODE_DIRECT, SWM_MODE_INDIRECT, SWM_MODE_BIT
   } swm_addr_mode_e;

   typedef struct packed {
      swm_alu_op_e op;
      logic        carry;
      logic        half_carry;
      logic [15:0] product;
      logic        div_zero;
   } swm_alu_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [2:0] bitpos;
      logic       to_sfr;
      logic       to_upper;
      logic       is_bit;
      logic       bit_ok;
   } swm_dmap_s;
endpackage

// ---- rtl/swm_addr_map.sv ----
`timescale 1ns/1ns
// =====================================================
// Data address decode
module swm_addr_map (
   input  wire logic [7:0]          addr,
   input  wire swm_pkg::swm_addr_mode_e mode,
   input  wire logic                use_r1,
   input  wire logic [1:0]          bank,
   input  wire logic [7:0]          r0_val,
   input  wire logic [7:0]          r1_val,
   output      swm_pkg::swm_dmap_s  dmap
);
   import swm_pkg::*;
   logic [7:0] ind;

   always_comb begin
      ind         = use_r1 ? r1_val : r0_val; // RULE16
      dmap        = '0;
      dmap.bitpos = addr[2:0];
      case (mode)
         SWM_MODE_INDIRECT: begin
            dmap.addr     = ind;
            dmap.to_upper = ind[7]; // RULE12
         end
         SWM_MODE_BIT: begin
            dmap.is_bit = 1'b1;
            if (!addr[7]) begin
               dmap.addr   = BIT_BYTE_BASE + {4'h0, addr[6:3]}; // RULE13
               dmap.bit_ok = 1'b1;
            end else begin
               dmap.addr   = {addr[7:3], 3'h0};
               dmap.to_sfr = 1'b1;
               dmap.bit_ok = 1'b1; // RULE20
            end
         end
         default: begin
            dmap.addr   = addr; // RULE11
            dmap.to_sfr = addr >= SFR_BASE; // RULE12
         end
      endcase
   end
endmodule // swm_addr_map

// ---- rtl/swm_status_word.sv ----
`timescale 1ns/1ns
// =====================================================
// Status word, stack pointer, data memory and on_chip_xdata_ram decode
module swm_status_word #(
   parameter int IRAM_DEPTH = 256,
   parameter int ON_CHIP_XDATA_RAM_DEPTH = 1024
) (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire swm_pkg::swm_alu_s      alu,
   input  wire logic [7:0]             acc_val,
   input  wire logic                   mem_req,
   input  wire logic                   mem_we,
   input  wire swm_pkg::swm_addr_mode_e mem_mode,
   input  wire logic                   mem_use_r1,
   input  wire logic [7:0]             mem_addr,
   input  wire logic [7:0]             mem_wdata,
   input  wire logic                   reg_req,
   input  wire logic                   reg_we,
   input  wire logic [2:0]             reg_num,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   push_req,
   input  wire logic                   pop_req,
   input  wire logic [7:0]             push_data,
   input  wire logic                   xm_req,
   input  wire logic                   xm_we,
   input  wire logic                   xm_use_data_pointer_pair,
   input  wire logic [15:0]            xm_data_pointer_pair,
   input  wire logic [7:0]             xm_wdata,
   input  wire logic                   code_req,
   input  wire logic [15:0]            code_addr,
   input  wire logic [7:0]             code_data,
   output      logic [7:0]             program_status_word,
   output      logic [7:0]             stack_pointer,
   output      logic [7:0]             rdata,
   output      logic                   rvalid,
   output      logic [15:0]            code_fetch_addr,
   output      logic                   code_fetch_en,
   output      logic                   code_reserved_hit
);
   import swm_pkg::*;

   // =====================================================
   // State
   logic [7:0]           psw_ff;
   logic [7:0]           sp_ff;
   logic [PAGE_BITS-1:0] page_ff;
   logic [7:0]           iram [IRAM_DEPTH];
   logic [7:0]           uram [IRAM_DEPTH/2];
   logic [7:0]           on_chip_xdata_ram [ON_CHIP_XDATA_RAM_DEPTH];
   logic [7:0]           rdata_ff;
   logic                 rvalid_ff;
   logic [15:0]          cfa_ff;
   logic                 cfe_ff;
   logic                 crh_ff;
   swm_dmap_s            dmap;
   logic [7:0]           sfr_rd;
   logic [7:0]           byte_rd;
   logic [7:0]           nxt_byte;
   logic [7:0]           nxt_psw_sw;
   logic                 sw_psw_wr;
   logic [7:0]           r0_val;
   logic [7:0]           r1_val;
   logic [ON_CHIP_XDATA_RAM_AW-1:0]   xaddr;
   logic [7:0]           sp_inc;

   // =====================================================
   // Decode helpers
   function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] rn);
      bank_addr = {3'h0, bank, rn}; // RULE3
   endfunction

   function automatic logic parity8(input logic [7:0] v);
      parity8 = ^v; // RULE6
   endfunction

   assign r0_val = iram[bank_addr(psw_ff[RS_HI:RS_LO], 3'h0)];
   assign r1_val = iram[bank_addr(psw_ff[RS_HI:RS_LO], 3'h1)];
   assign sp_inc = sp_ff + 8'h01;

   swm_addr_map u_map (
      .addr   (mem_addr),
      .mode   (mem_mode),
      .use_r1 (mem_use_r1),
      .bank   (psw_ff[RS_HI:RS_LO]),
      .r0_val (r0_val),
      .r1_val (r1_val),
      .dmap   (dmap)
   );

   assign xaddr = xm_use_data_pointer_pair ? xm_data_pointer_pair[ON_CHIP_XDATA_RAM_AW-1:0] // RULE18
                              : {page_ff, mem_use_r1 ? r1_val : r0_val}; // RULE16 RULE17

   // =====================================================
   // Special register read mux
   always_comb begin
      case (dmap.addr)
         PSW_ADDR:  sfr_rd = {psw_ff[7:1], parity8(acc_val)}; // RULE6
         SP_ADDR:   sfr_rd = sp_ff;
         PAGE_ADDR: sfr_rd = {{(8-PAGE_BITS){1'b0}}, page_ff}; // RULE19
         ACC_ADDR:  sfr_rd = acc_val;
         default:   sfr_rd = 8'h00;
      endcase
   end

   always_comb begin
      if (dmap.to_sfr) begin
         byte_rd = sfr_rd;
      end else if (dmap.to_upper) begin
         byte_rd = uram[dmap.addr[6:0]];
      end else begin
         byte_rd = iram[dmap.addr];
      end
   end

   // Bit write merges into the read byte
   always_comb begin
      nxt_byte = mem_wdata;
      if (dmap.is_bit) begin
         nxt_byte = byte_rd;
         nxt_byte[dmap.bitpos] = mem_wdata[0]; // RULE7 RULE13
      end
   end

   assign sw_psw_wr  = mem_req && mem_we && dmap.to_sfr && (dmap.bit_ok || !dmap.is_bit) // RULE20
                       && (dmap.addr == PSW_ADDR); // RULE8
   assign nxt_psw_sw = {nxt_byte[7:1], 1'b0}; // RULE21

   // =====================================================
   // Status word
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         psw_ff <= PSW_RESET; // RULE8
      end else begin
         if (sw_psw_wr) begin
            psw_ff <= nxt_psw_sw;
         end
         case (alu.op)
            SWM_OP_ADD, SWM_OP_ADD_WITH_CARRY_OP, SWM_OP_SUBTRACT_BORROW_OP: begin
               psw_ff[CY_POS] <= alu.carry; // RULE1
               psw_ff[AC_POS] <= alu.half_carry; // RULE2
               psw_ff[OV_POS] <= 1'b0; // RULE5
            end
            SWM_OP_MUL: begin
               psw_ff[CY_POS] <= 1'b0; // RULE1
               psw_ff[OV_POS] <= alu.product > {7'h00, MUL_LIMIT}; // RULE4 RULE5
            end
            SWM_OP_DIV: begin
               psw_ff[CY_POS] <= 1'b0; // RULE1
               psw_ff[OV_POS] <= alu.div_zero; // RULE4 RULE5
            end
            default: begin
            end
         endcase
      end
   end

   // =====================================================
   // Stack pointer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sp_ff <= SP_RESET; // RULE15
      end else if (push_req) begin
         sp_ff <= sp_inc; // RULE14
      end else if (pop_req) begin
         sp_ff <= sp_ff - 8'h01;
      end else if (mem_req && mem_we && dmap.to_sfr && dmap.addr == SP_ADDR) begin
         sp_ff <= nxt_byte;
      end
   end

   // =====================================================
   // Page select
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         page_ff <= PAGE_RESET[PAGE_BITS-1:0];
      end else if (mem_req && mem_we && dmap.to_sfr && dmap.addr == PAGE_ADDR) begin
         page_ff <= nxt_byte[PAGE_BITS-1:0]; // RULE19
      end
   end

   // =====================================================
   // Internal and upper RAM, on_chip_xdata_ram writes
   always_ff @(posedge clk) begin
      if (push_req) begin
         iram[sp_inc] <= push_data; // RULE14
      end else if (reg_req && reg_we) begin
         iram[bank_addr(psw_ff[RS_HI:RS_LO], reg_num)] <= reg_wdata; // RULE3
      end else if (mem_req && mem_we && !dmap.to_sfr) begin
         if (dmap.to_upper) begin
            uram[dmap.addr[6:0]] <= nxt_byte; // RULE12
         end else begin
            iram[dmap.addr] <= nxt_byte; // RULE11
         end
      end
      if (xm_req && xm_we) begin
         on_chip_xdata_ram[xaddr] <= xm_wdata;
      end
   end

   // =====================================================
   // Read return
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= (mem_req && !mem_we) || (reg_req && !reg_we) || pop_req || (xm_req && !xm_we) || code_req;
         if (code_req) begin
            rdata_ff <= code_data; // RULE10
         end else if (xm_req && !xm_we) begin
            rdata_ff <= on_chip_xdata_ram[xaddr];
         end else if (pop_req) begin
            rdata_ff <= iram[sp_ff];
         end else if (reg_req && !reg_we) begin
            rdata_ff <= iram[bank_addr(psw_ff[RS_HI:RS_LO], reg_num)];
         end else if (mem_req && !mem_we) begin
            rdata_ff <= dmap.is_bit ? {7'h00, byte_rd[dmap.bitpos]} : byte_rd;
         end
      end
   end

   // =====================================================
   // Code read port, read only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfa_ff <= 16'h0000;
         cfe_ff <= 1'b0;
         crh_ff <= 1'b0;
      end else begin
         cfe_ff <= code_req; // RULE10
         if (code_req) begin
            cfa_ff <= code_addr;
         end
         crh_ff <= code_req && (code_addr > CODE_USER_END); // RULE9
      end
   end

   assign program_status_word = psw_ff;
   assign stack_pointer       = sp_ff;
   assign rdata               = rdata_ff;
   assign rvalid              = rvalid_ff;
   assign code_fetch_addr     = cfa_ff;
   assign code_fetch_en       = cfe_ff;
   assign code_reserved_hit   = crh_ff;
endmodule // swm_status_word

// ---- verif/swm_status_word_sva.sv ----
`timescale 1ns/1ns
// =====================================================
// Status word checker
module swm_status_word_sva (
   input wire logic                    clk,
   input wire logic                    arst_n,
   input wire swm_pkg::swm_alu_s       alu,
   input wire logic [7:0]              acc_val,
   input wire logic                    mem_req,
   input wire logic                    mem_we,
   input wire swm_pkg::swm_addr_mode_e mem_mode,
   input wire logic [7:0]              mem_addr,
   input wire logic                    push_req,
   input wire logic                    pop_req,
   input wire logic                    code_req,
   input wire logic [15:0]             code_addr,
   input wire logic [7:0]              program_status_word,
   input wire logic [7:0]              stack_pointer,
   input wire logic [7:0]              rdata,
   input wire logic                    rvalid,
   input wire logic                    code_reserved_hit
);
   import swm_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire add_op = alu.op inside {SWM_OP_ADD, SWM_OP_ADD_WITH_CARRY_OP, SWM_OP_SUBTRACT_BORROW_OP};
   wire psw_rd = mem_req && !mem_we && mem_mode == SWM_MODE_DIRECT && mem_addr == 8'hd0;
   a_reset_vals: assert property ($rose(arst_n) |-> program_status_word == 8'h00 && stack_pointer == 8'h07)
      else $error("reset values wrong");
   a_push_inc: assert property (push_req |=> stack_pointer == $past(stack_pointer) + 8'h01)
      else $error("push did not bump stack pointer");
   a_pop_dec: assert property (pop_req |=> stack_pointer == $past(stack_pointer) - 8'h01)
      else $error("pop did not drop stack pointer");
   a_carry_arith: assert property (add_op |=> program_status_word[7] == $past(alu.carry))
      else $error("carry flag wrong");
   a_half_carry: assert property (add_op |=> program_status_word[6] == $past(alu.half_carry))
      else $error("half carry flag wrong");
   a_ov_add: assert property (add_op |=> !program_status_word[2])
      else $error("overflow not cleared");
   a_ov_mul: assert property (alu.op == SWM_OP_MUL |=> program_status_word[2] == ($past(alu.product) > 16'h00ff))
      else $error("multiply overflow wrong");
   a_ov_div: assert property (alu.op == SWM_OP_DIV |=> program_status_word[2] == $past(alu.div_zero))
      else $error("divide overflow wrong");
   a_par_held: assert property (program_status_word[0] == 1'b0)
      else $error("parity stored in register");
   a_psw_read: assert property (psw_rd |=> rvalid && rdata == ($past(program_status_word) & 8'hfe | {7'h00, ^$past(acc_val)}))
      else $error("status read wrong");
   a_code_hit: assert property (code_req |=> rvalid && code_reserved_hit == ($past(code_addr) > 16'h3dff))
      else $error("code read flag wrong");
endmodule // swm_status_word_sva
bind swm_status_word swm_status_word_sva u_swm_status_word_sva (.*);

// ---- verif/swm_code_rom.sv ----
`timescale 1ns/1ns
// =====================================================
// Program memory behind the code-read path
module swm_code_rom (
   input  wire logic [15:0] code_addr,
   output      logic [7:0]  code_data
);
   // No write path at all
   assign code_data = code_addr[15:8] ^ code_addr[7:0] ^ 8'ha5;
endmodule // swm_code_rom

// ---- verif/swm_status_word_tb.sv ----
`timescale 1ns/1ns
// =====================================================
// Status word bench
module swm_status_word_tb;
   import swm_pkg::*;
   typedef struct packed {swm_alu_s a; logic [7:0] e;} swm_row_s;
   logic clk, arst_n, mem_req, mem_we, mem_use_r1, reg_req, reg_we, push_req, pop_req;
   logic xm_req, xm_we, xm_use_data_pointer_pair, code_req, rvalid, code_fetch_en, code_reserved_hit;
   logic [2:0] reg_num;
   logic [7:0] acc_val, mem_addr, mem_wdata, reg_wdata, push_data, xm_wdata, code_data;
   logic [7:0] program_status_word, stack_pointer, rdata;
   logic [15:0] xm_data_pointer_pair, code_addr, code_fetch_addr;
   swm_alu_s alu;
   swm_addr_mode_e mem_mode;
   swm_row_s rows [9];
   int mismatches, total_checks;
   swm_status_word u_swm_status_word (.*);
   swm_code_rom u_swm_code_rom (.*);
   task automatic chk(input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic fin();
      @(posedge clk);
      {mem_req, reg_req, push_req, pop_req, xm_req, code_req} <= '0;
      #1;
   endtask
   task automatic mem(input logic we, input swm_addr_mode_e md, input logic [7:0] a, d);
      @(posedge clk);
      {mem_req, mem_we, mem_addr, mem_wdata} <= {1'b1, we, a, d};
      mem_mode <= md;
      fin();
   endtask
   task automatic regw(input logic [2:0] n, input logic [7:0] d);
      @(posedge clk);
      {reg_req, reg_we, reg_num, reg_wdata} <= {2'b11, n, d};
      fin();
   endtask
   task automatic stk(input logic pop, input logic [7:0] d);
      @(posedge clk);
      {push_req, pop_req, push_data} <= {~pop, pop, d};
      fin();
   endtask
   task automatic xm(input logic we, dp, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      {xm_req, xm_we, xm_use_data_pointer_pair, xm_data_pointer_pair, xm_wdata} <= {1'b1, we, dp, a, d};
      fin();
   endtask
   task automatic code(input logic [15:0] a);
      @(posedge clk);
      {code_req, code_addr} <= {1'b1, a};
      fin();
   endtask
   task automatic results();
      $display("Checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      results();
   end
   initial begin
      arst_n = 1'b0;
      alu = '0;
      acc_val = 8'h07;
      {mem_req, mem_we, mem_use_r1, reg_req, reg_we, push_req, pop_req} = '0;
      {xm_req, xm_we, xm_use_data_pointer_pair, code_req, reg_num, mem_addr, mem_wdata} = '0;
      {reg_wdata, push_data, xm_wdata, xm_data_pointer_pair, code_addr} = '0;
      mem_mode = SWM_MODE_DIRECT;
      rows[0] = '{'{SWM_OP_ADD, 1'b1, 1'b0, 16'h0000, 1'b0}, 8'h80};
      rows[1] = '{'{SWM_OP_MUL, 1'b1, 1'b0, 16'h0100, 1'b0}, 8'h04};
      rows[2] = '{'{SWM_OP_MUL, 1'b0, 1'b0, 16'h00ff, 1'b0}, 8'h00};
      rows[3] = '{'{SWM_OP_DIV, 1'b0, 1'b0, 16'h0000, 1'b1}, 8'h04};
      rows[4] = '{'{SWM_OP_OTHER, 1'b1, 1'b1, 16'h0000, 1'b0}, 8'h04};
      rows[5] = '{'{SWM_OP_ADD_WITH_CARRY_OP, 1'b0, 1'b1, 16'h0000, 1'b0}, 8'h40};
      rows[6] = '{'{SWM_OP_SUBTRACT_BORROW_OP, 1'b1, 1'b0, 16'h0000, 1'b0}, 8'h80};
      rows[7] = '{'{SWM_OP_DIV, 1'b1, 1'b0, 16'h0000, 1'b0}, 8'h00};
      rows[8] = '{'{SWM_OP_NONE, 1'b1, 1'b1, 16'hffff, 1'b1}, 8'h00};
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk(program_status_word, 8'h00);
      chk(stack_pointer, 8'h07);
      $display("Reset test done");
      foreach (rows[i]) begin
         @(posedge clk);
         alu <= rows[i].a;
         @(posedge clk);
         alu.op <= SWM_OP_NONE;
         #1;
         chk(program_status_word & 8'hc4, rows[i].e);
      end
      $display("Flag table done");
      stk(1'b0, 8'h3c);
      chk(stack_pointer, 8'h08);
      mem(1'b0, SWM_MODE_DIRECT, 8'h08, 8'h00);
      chk(rdata, 8'h3c);
      stk(1'b1, 8'h00);
      chk(stack_pointer, 8'h07);
      $display("Stack test done");
      mem(1'b1, SWM_MODE_DIRECT, 8'hd0, 8'h3b);
      chk(program_status_word, 8'h3a);
      mem(1'b0, SWM_MODE_DIRECT, 8'hd0, 8'h00);
      chk(rdata, 8'h3b);
      @(posedge clk) acc_val <= 8'h03;
      mem(1'b0, SWM_MODE_DIRECT, 8'hd0, 8'h00);
      chk(rdata, 8'h3a);
      mem(1'b1, SWM_MODE_BIT, 8'hd5, 8'h00);
      chk(program_status_word, 8'h1a);
      regw(3'h2, 8'h77);
      mem(1'b0, SWM_MODE_DIRECT, 8'h1a, 8'h00);
      chk(rdata, 8'h77);
      regw(3'h0, 8'h81);
      mem(1'b1, SWM_MODE_INDIRECT, 8'h00, 8'h5a);
      mem(1'b0, SWM_MODE_DIRECT, 8'h81, 8'h00);
      chk(rdata, 8'h07);
      mem(1'b0, SWM_MODE_INDIRECT, 8'h00, 8'h00);
      chk(rdata, 8'h5a);
      mem(1'b1, SWM_MODE_DIRECT, 8'h22, 8'h00);
      mem(1'b1, SWM_MODE_BIT, 8'h13, 8'h01);
      mem(1'b0, SWM_MODE_DIRECT, 8'h22, 8'h00);
      chk(rdata, 8'h08);
      mem(1'b0, SWM_MODE_BIT, 8'h13, 8'h00);
      chk(rdata, 8'h01);
      $display("Map test done");
      mem(1'b1, SWM_MODE_DIRECT, 8'haa, 8'hff);
      mem(1'b0, SWM_MODE_DIRECT, 8'haa, 8'h00);
      chk(rdata, 8'h03);
      xm(1'b1, 1'b0, 16'h0000, 8'hc3);
      xm(1'b0, 1'b1, 16'hfb81, 8'h00);
      chk(rdata, 8'hc3);
      code(16'h3e00);
      chk({7'h00, code_reserved_hit}, 8'h01);
      chk(rdata, 8'h9b);
      chk(code_fetch_addr[15:8], 8'h3e);
      chk({7'h00, code_fetch_en}, 8'h01);
      code(16'h3dff);
      chk({7'h00, code_reserved_hit}, 8'h00);
      chk(rdata, 8'h67);
      chk(code_fetch_addr[7:0], 8'hff);
      $display("On_chip_xdata_ram and code test done");
      results();
   end
endmodule // swm_status_word_tb
